//--- hw/wwd_top.sv
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// (R1) Run enable sticks once fed until reset.
// (R2) Later writes of zero to run ignored.
// (R3) Warning raised one tick after reaching compare.
// (R4) Each completed feed reloads counter from reload.
// (R5) Reload below 0xFF stored as 0xFF; prescale four.
// (R6) Protected reload change too early forces reset.
// (R7) Feed above window is a watchdog event.
// (R8) Window at maximum accepts feeds anytime.
// (R9) Software feeds with two successive words.
// (R10) Software feeds before timeout or reset follows.
// (R11) Timeout requests reset only when enabled.
// (R12) Timeout sets a readable clearable flag.
// (R13) Warning sets a readable clearable flag.
// (R14) Oscillator lock blocks power down until reset.
// (R15) Warning compare of zero gives no warning.
// (R16) Unprotected reload rewrite never causes reset.
// (R17) Counter counts down; zero while running times out.
module wwd_top
  import wwd_pkg::*;
(
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Watchdog tick, synchronous to aclk.
  input wire logic wd_tick,
  // AXI4-Lite write address.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Outputs to the system.
  output logic irq,
  output logic chip_reset_req,
  output logic osc_lock
);

  logic [7:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic w_have_r;
  logic [3:0] mode_r;
  logic running_r;
  logic [CNT_W-1:0] reload_r;
  logic [CNT_W-1:0] window_r;
  logic [WARN_W-1:0] warn_r;
  logic [CNT_W-1:0] count_r;
  logic [1:0] presc_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic warn_pend_r;
  wwd_feed_t feed_r;

  logic wr_go;
  logic wr_ok;
  logic rd_go;
  logic rd_ok;
  logic [31:0] rd_val;
  logic [CNT_W-1:0] wdata_cnt;
  logic wr_mode, wr_reload, wr_feed, wr_warn, wr_window;
  logic wr_status, wr_mask;
  logic feed_done;
  logic step;
  logic timeout_ev;
  logic window_ev;
  logic protect_ev;
  logic warn_now;
  logic warn_ev;

  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wdata_cnt = w_data_r[CNT_W-1:0];

  always_comb begin
    wr_mode = 1'b0;
    wr_reload = 1'b0;
    wr_feed = 1'b0;
    wr_warn = 1'b0;
    wr_window = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    wr_ok = 1'b1;
    if (aw_addr_r == ADDR_MODE) begin
      wr_mode = wr_go;
    end else if (aw_addr_r == ADDR_RELOAD) begin
      wr_reload = wr_go;
    end else if (aw_addr_r == ADDR_FEED) begin
      wr_feed = wr_go;
    end else if (aw_addr_r == ADDR_WARN) begin
      wr_warn = wr_go;
    end else if (aw_addr_r == ADDR_WINDOW) begin
      wr_window = wr_go;
    end else if (aw_addr_r == ADDR_STATUS) begin
      wr_status = wr_go;
    end else if (aw_addr_r == ADDR_MASK) begin
      wr_mask = wr_go;
    end else if (aw_addr_r != ADDR_COUNT) begin
      wr_ok = 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr == ADDR_MODE) begin
      rd_val = {28'h0000000, mode_r};
    end else if (s_axi_araddr == ADDR_RELOAD) begin
      rd_val = {8'h00, reload_r};
    end else if (s_axi_araddr == ADDR_FEED) begin
      rd_val = 32'h00000000;
    end else if (s_axi_araddr == ADDR_COUNT) begin
      rd_val = {8'h00, count_r};
    end else if (s_axi_araddr == ADDR_WARN) begin
      rd_val = {22'h0, warn_r};
    end else if (s_axi_araddr == ADDR_WINDOW) begin
      rd_val = {8'h00, window_r};
    end else if (s_axi_araddr == ADDR_STATUS) begin
      rd_val = {30'h0, status_r};
    end else if (s_axi_araddr == ADDR_MASK) begin
      rd_val = {30'h0, mask_r};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Write channel: address and data are captured independently.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (clk_en) begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Mode bits other than the reset option only ever set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= MODE_RST;
    end else if (clk_en && wr_mode) begin
      if (w_data_r[MODE_RUN_BIT]) begin
        mode_r[MODE_RUN_BIT] <= 1'b1; // (R1) (R2)
      end
      mode_r[MODE_RESET_BIT] <= w_data_r[MODE_RESET_BIT];
      if (w_data_r[MODE_PROTECT_BIT]) begin
        mode_r[MODE_PROTECT_BIT] <= 1'b1;
      end
      if (w_data_r[MODE_LOCK_BIT]) begin
        mode_r[MODE_LOCK_BIT] <= 1'b1; // (R14)
      end
    end
  end

  // Limit values.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_r <= RELOAD_RST;
      window_r <= WINDOW_RST;
      warn_r <= WARN_RST;
      mask_r <= STATUS_RST;
    end else if (clk_en) begin
      if (wr_reload) begin
        reload_r <= (wdata_cnt < RELOAD_MIN) ? RELOAD_MIN : wdata_cnt; // (R5)
      end
      if (wr_window) begin
        window_r <= wdata_cnt;
      end
      if (wr_warn) begin
        warn_r <= w_data_r[WARN_W-1:0];
      end
      if (wr_mask) begin
        mask_r <= w_data_r[1:0];
      end
    end
  end

  // Feed sequence: first word arms, second word completes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feed_r <= FEED_IDLE;
    end else if (clk_en && wr_go) begin
      case (feed_r)
        FEED_IDLE: begin
          if (wr_feed && w_data_r[7:0] == FEED_FIRST) begin
            feed_r <= FEED_ARMED; // (R9)
          end
        end
        default: begin
          feed_r <= (wr_feed && w_data_r[7:0] == FEED_FIRST) ?
            FEED_ARMED : FEED_IDLE;
        end
      endcase
    end
  end

  assign feed_done = wr_feed && feed_r == FEED_ARMED &&
    w_data_r[7:0] == FEED_SECOND;
  assign step = running_r && wd_tick && presc_r == PRESCALE_LAST; // (R5)
  assign timeout_ev = step && count_r == {CNT_W{1'b0}}; // (R17) (R10)
  assign window_ev = feed_done && running_r &&
    window_r != CNT_MAX && count_r > window_r; // (R7) (R8)
  assign protect_ev = wr_reload && mode_r[MODE_PROTECT_BIT] &&
    (count_r >= {{(CNT_W-WARN_W){1'b0}}, warn_r} ||
     count_r >= window_r); // (R6) (R16)
  assign warn_now = warn_r != WARN_RST &&
    count_r <= {{(CNT_W-WARN_W){1'b0}}, warn_r}; // (R15)
  assign warn_ev = warn_pend_r && wd_tick; // (R3)

  // Counter and prescaler.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running_r <= 1'b0;
      count_r <= RELOAD_RST;
      presc_r <= 2'h0;
    end else if (clk_en) begin
      if (feed_done && mode_r[MODE_RUN_BIT]) begin
        running_r <= 1'b1; // (R1)
      end
      if (running_r && wd_tick) begin
        presc_r <= presc_r + 2'h1;
      end
      if (feed_done) begin
        count_r <= reload_r; // (R4)
        presc_r <= 2'h0;
      end else if (timeout_ev) begin
        count_r <= reload_r;
      end else if (step) begin
        count_r <= count_r - {{(CNT_W-1){1'b0}}, 1'b1}; // (R17)
      end
    end
  end

  // Warning pends until the following watchdog tick.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_pend_r <= 1'b0;
    end else if (clk_en) begin
      if (warn_ev || feed_done) begin
        warn_pend_r <= 1'b0;
      end else if (running_r && warn_now && !status_r[ST_WARN_BIT]) begin
        warn_pend_r <= 1'b1; // (R3)
      end
    end
  end

  // Sticky status: a set in the same cycle beats a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= STATUS_RST;
    end else if (clk_en) begin
      if (timeout_ev || window_ev || protect_ev) begin
        status_r[ST_TIMEOUT_BIT] <= 1'b1; // (R12)
      end else if (wr_status && w_data_r[ST_TIMEOUT_BIT]) begin
        status_r[ST_TIMEOUT_BIT] <= 1'b0;
      end
      if (warn_ev) begin
        status_r[ST_WARN_BIT] <= 1'b1; // (R13)
      end else if (wr_status && w_data_r[ST_WARN_BIT]) begin
        status_r[ST_WARN_BIT] <= 1'b0;
      end
    end
  end

  // System outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      chip_reset_req <= 1'b0;
      osc_lock <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status_r & mask_r);
      if (protect_ev || ((timeout_ev || window_ev) &&
          mode_r[MODE_RESET_BIT])) begin
        chip_reset_req <= 1'b1; // (R11) (R6)
      end
      osc_lock <= mode_r[MODE_LOCK_BIT]; // (R14)
    end
  end

endmodule

//--- hw/wwd_pkg.sv
package wwd_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_RELOAD = 8'h04;
  localparam logic [7:0] ADDR_FEED = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_WARN = 8'h10;
  localparam logic [7:0] ADDR_WINDOW = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;

  // Mode control register bit positions.
  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_RESET_BIT = 1;
  localparam int MODE_PROTECT_BIT = 2;
  localparam int MODE_LOCK_BIT = 3;

  // Status and mask bit positions.
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_WARN_BIT = 1;

  // Counter geometry and reset values.
  localparam int CNT_W = 24;
  localparam int WARN_W = 10;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] RELOAD_MIN = 24'h0000FF;
  localparam logic [CNT_W-1:0] RELOAD_RST = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] WINDOW_RST = 24'hFFFFFF;
  localparam logic [WARN_W-1:0] WARN_RST = 10'h000;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] STATUS_RST = 2'h0;

  // Feed sequence words.
  localparam logic [7:0] FEED_FIRST = 8'hAA;
  localparam logic [7:0] FEED_SECOND = 8'h55;

  // Watchdog ticks per counter decrement.
  localparam int PRESCALE = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE - 1);

  typedef enum logic [0:0] {
    FEED_IDLE = 1'b0,
    FEED_ARMED = 1'b1
  } wwd_feed_t;

endpackage

//--- verification/wwd_monitor.sv
`timescale 1ns/1ps
module wwd_monitor (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // System outputs.
  input wire logic chip_reset_req,
  input wire logic osc_lock
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_data_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while busy");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_reset_sticky: assert property (chip_reset_req |=> chip_reset_req)
    else $error("reset request dropped");
  a_lock_sticky: assert property (osc_lock |=> osc_lock)
    else $error("lock dropped");
endmodule

bind wwd_top wwd_monitor i_wwd_monitor (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .chip_reset_req, .osc_lock);

//--- verification/windowed_watchdog_timer_test.sv
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
  import wwd_pkg::*;
  logic aclk, aresetn, wd_tick, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic clk_en;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, irq;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, chip_reset_req, osc_lock;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
  int num_errors = 0;
  int total_checks = 0;
  logic [7:0] ta [5] = '{ADDR_RELOAD, ADDR_RELOAD, ADDR_WARN, ADDR_WINDOW,
    8'h20};
  logic [31:0] td [5] = '{32'h10, 32'h300, 32'h3FF, 32'h123456, 32'h7};
  logic [31:0] te [5] = '{32'hFF, 32'h300, 32'h3FF, 32'h123456, 32'h0};

  wwd_top i_wwd_top (.aclk, .aresetn, .clk_en, .wd_tick, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .chip_reset_req, .osc_lock);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang(input int n);
    if (n > 100) begin
      num_errors++;
      $display("MISMATCH %0t bus wait timed out", $time);
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      hang(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      hang(n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge aclk);
      wd_tick <= 1'b1;
      @(posedge aclk);
      wd_tick <= 1'b0;
    end
  endtask

  task automatic feed;
    wr(ADDR_FEED, {24'h0, FEED_FIRST});
    wr(ADDR_FEED, {24'h0, FEED_SECOND});
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    cyc(16);
    aresetn <= 1'b1;
  endtask

  initial begin
    {aresetn, wd_tick, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    clk_en = 1'b1;
    do_reset();
    for (int i = 0; i < 5; i++) begin
      wr(ta[i], td[i]);
      rd(ta[i]);
      chk(rv, te[i]);
    end
    chk(br, 2'h2);
    chk(rr, 2'h2);
    $display("Test register table done");
    do_reset();
    rd(ADDR_RELOAD);
    chk(rv, {8'h0, RELOAD_RST});
    rd(ADDR_WINDOW);
    chk(rv, {8'h0, WINDOW_RST});
    rd(ADDR_MODE);
    chk(rv, 32'h0);
    $display("Test reset values done");
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_RELOAD, 32'h100);
    feed();
    rd(ADDR_COUNT);
    chk(rv, 32'h100);
    rd(ADDR_STATUS);
    chk(rv, 32'h0);
    wr(ADDR_MODE, 32'h0);
    rd(ADDR_MODE);
    chk(rv, 32'h1);
    tick(4);
    rd(ADDR_COUNT);
    chk(rv, 32'hFF);
    // With the clock enable low, ticks must not move the counter.
    clk_en <= 1'b0;
    tick(8);
    clk_en <= 1'b1;
    rd(ADDR_COUNT);
    chk(rv, 32'hFF);
    $display("Test feed done");
    wr(ADDR_WARN, 32'h3FF);
    rd(ADDR_STATUS);
    chk(rv, 32'h0);
    tick(1);
    cyc(2);
    chk(irq, 1'b0);
    rd(ADDR_STATUS);
    chk(rv, 32'h2);
    wr(ADDR_MASK, 32'h2);
    cyc(2);
    chk(irq, 1'b1);
    wr(ADDR_STATUS, 32'h2);
    cyc(2);
    chk(irq, 1'b0);
    $display("Test warning done");
    wr(ADDR_WINDOW, 32'h10);
    feed();
    rd(ADDR_STATUS);
    chk(rv, 32'h1);
    chk(chip_reset_req, 1'b0);
    wr(ADDR_MODE, 32'h4);
    wr(ADDR_RELOAD, 32'h200);
    cyc(2);
    chk(chip_reset_req, 1'b1);
    $display("Test window and protect done");
    do_reset();
    chk(chip_reset_req, 1'b0);
    wr(ADDR_MODE, 32'hB);
    wr(ADDR_MODE, 32'h2);
    cyc(2);
    chk(osc_lock, 1'b1);
    wr(ADDR_RELOAD, 32'h10);
    feed();
    tick(1030);
    cyc(2);
    chk(chip_reset_req, 1'b1);
    rd(ADDR_STATUS);
    chk(rv, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS);
    chk(rv, 32'h0);
    do_reset();
    chk(osc_lock, 1'b0);
    $display("Test timeout done");
    print_verdict();
  end
endmodule
